// [core/cpu_core_register_set.sv]
// Programmer-visible register set of a 16-bit core, with datapath and APB ports.
// Assumes the execution datapath and APB master run on pclk; no pin inputs.
`timescale 1ns/1ps

module cpu_core_register_set
  import cpu_regs_pkg::*;
(
  input  wire logic                pclk,               // Core clock, 250 MHz
  input  wire logic                presetn,            // Async reset, active low
  input  wire logic                ce,                 // Clock enable, freezes all state
  // APB slave
  input  wire logic                psel,               // Slave select
  input  wire logic                penable,            // Access phase
  input  wire logic                pwrite,             // Write direction
  input  wire logic [PADDR_W-1:0]  paddr,              // Byte address
  input  wire logic [LONG_W-1:0]   pwdata,             // Write data
  output logic                     pready,             // Transfer done
  output logic [LONG_W-1:0]        prdata,             // Read data
  output logic                     pslverr,            // Unmapped address
  // Datapath operand reads
  input  wire reg_sel_t            rd_a_sel,           // Operand A selector
  input  wire reg_sel_t            rd_b_sel,           // Operand B selector
  output logic [LONG_W-1:0]        rd_a_data,          // Operand A, next cycle
  output logic [LONG_W-1:0]        rd_b_data,          // Operand B, next cycle
  // Datapath writes
  input  wire wr_req_t             wr_req,             // Operand write request
  input  wire logic                fetch_ptr_load,     // Load next fetch pointer
  input  wire logic [WIDE_W-1:0]   fetch_ptr_value,    // New fetch pointer
  input  wire logic                flag_we,            // Write stack-select flag
  input  wire logic                flag_value,         // New stack-select flag
  input  wire logic                hw_int_ack,         // Hardware interrupt taken
  input  wire logic                soft_int_exec,      // Software interrupt executed
  input  wire logic [INTNUM_W-1:0] soft_int_num,       // Software interrupt number
  // Address views
  output logic [WORD_W-1:0]        pointer_lo,         // Pointer register low
  output logic [WORD_W-1:0]        pointer_hi,         // Pointer register high
  output logic [WORD_W-1:0]        frame_base,         // Frame base
  output logic [WIDE_W-1:0]        vector_table_base,  // Vector table start
  output logic [WIDE_W-1:0]        next_fetch_pointer, // Next instruction address
  output logic [WORD_W-1:0]        active_stack_ptr,   // Selected stack pointer
  output logic                     stack_sel           // Stack-select flag
);

  // ==========================================================================
  // Operand and APB read decode

  // Gather one operand, bytes and words zero-extended
  function automatic logic [LONG_W-1:0] operand_read(regs_state_t s, reg_sel_t sel);
    logic [LONG_W-1:0] v;
    v = RST_LONG;
    case (sel)
      SEL_DATA_WORD_0:      v = {16'h0000, s.data_word_0};
      SEL_DATA_WORD_1:      v = {16'h0000, s.data_word_1};
      SEL_DATA_WORD_2:      v = {16'h0000, s.data_word_2};
      SEL_DATA_WORD_3:      v = {16'h0000, s.data_word_3};
      SEL_WORD0_HIGH_BYTE:  v = {24'h000000, s.data_word_0[WORD_W-1:BYTE_W]};
      SEL_WORD0_LOW_BYTE:   v = {24'h000000, s.data_word_0[BYTE_W-1:0]};
      SEL_WORD1_HIGH_BYTE:  v = {24'h000000, s.data_word_1[WORD_W-1:BYTE_W]};
      SEL_WORD1_LOW_BYTE:   v = {24'h000000, s.data_word_1[BYTE_W-1:0]};
      SEL_LONG_PAIR_FIRST:  v = {s.data_word_2, s.data_word_0};
      SEL_LONG_PAIR_SECOND: v = {s.data_word_3, s.data_word_1};
      SEL_POINTER_LO:       v = {16'h0000, s.pointer_lo};
      SEL_POINTER_HI:       v = {16'h0000, s.pointer_hi};
      SEL_POINTER_PAIR:     v = {s.pointer_hi, s.pointer_lo};
      SEL_FRAME_BASE:       v = {16'h0000, s.frame_base};
      SEL_ACTIVE_STACK_PTR: v = {16'h0000, stack_view(s)};
      default:              v = RST_LONG;
    endcase
    return v;
  endfunction

  // Active stack pointer chosen by the flag
  function automatic logic [WORD_W-1:0] stack_view(regs_state_t s);
    return s.stack_sel ? s.user_stack_ptr : s.interrupt_stack_ptr;
  endfunction

  // APB read mux, zero above the register width
  function automatic logic [LONG_W-1:0] apb_read(regs_state_t s, logic [PADDR_W-1:0] a);
    logic [LONG_W-1:0] v;
    v = RST_LONG;
    case (a)
      OFS_DATA_WORD_0:   v = {16'h0000, s.data_word_0};
      OFS_DATA_WORD_1:   v = {16'h0000, s.data_word_1};
      OFS_DATA_WORD_2:   v = {16'h0000, s.data_word_2};
      OFS_DATA_WORD_3:   v = {16'h0000, s.data_word_3};
      OFS_POINTER_LO:    v = {16'h0000, s.pointer_lo};
      OFS_POINTER_HI:    v = {16'h0000, s.pointer_hi};
      OFS_FRAME_BASE:    v = {16'h0000, s.frame_base};
      OFS_VECTOR_BASE:   v = {12'h000, s.vector_table_base};
      OFS_FETCH_POINTER: v = {12'h000, s.next_fetch_pointer};
      OFS_USER_STACK:    v = {16'h0000, s.user_stack_ptr};
      OFS_INT_STACK:     v = {16'h0000, s.interrupt_stack_ptr};
      OFS_CPU_FLAG_WORD: v = {31'h0, s.stack_sel};
      default:           v = RST_LONG;
    endcase
    return v;
  endfunction

  // Address decode hit
  function automatic logic apb_hit(logic [PADDR_W-1:0] a);
    return (a[1:0] == 2'h0) && (a <= OFS_CPU_FLAG_WORD);
  endfunction

  // ==========================================================================
  // State

  regs_state_t st;
  regs_state_t next_st;
  logic        apb_setup;
  logic        apb_access;
  logic        soft_clears;

  // Bus phase decode
  assign apb_setup   = ce && psel && !penable;
  assign apb_access  = ce && psel && penable;
  assign soft_clears = soft_int_exec && (soft_int_num <= SOFT_INT_LAST);

  // Next-state logic: APB first, datapath overrides
  always_comb
  begin
    next_st = st;
    if (ce)
    begin
      // Latch read answer during the setup cycle
      if (apb_setup)
      begin
        next_st.prdata  = apb_read(st, paddr);
        next_st.pslverr = !apb_hit(paddr);
      end
      if (apb_access && pwrite)
      begin
        case (paddr)
          OFS_DATA_WORD_0:   next_st.data_word_0 = pwdata[WORD_W-1:0];
          OFS_DATA_WORD_1:   next_st.data_word_1 = pwdata[WORD_W-1:0];
          OFS_DATA_WORD_2:   next_st.data_word_2 = pwdata[WORD_W-1:0];
          OFS_DATA_WORD_3:   next_st.data_word_3 = pwdata[WORD_W-1:0];
          OFS_POINTER_LO:    next_st.pointer_lo = pwdata[WORD_W-1:0];
          OFS_POINTER_HI:    next_st.pointer_hi = pwdata[WORD_W-1:0];
          OFS_FRAME_BASE:    next_st.frame_base = pwdata[WORD_W-1:0];
          OFS_VECTOR_BASE:   next_st.vector_table_base = pwdata[WIDE_W-1:0];
          OFS_FETCH_POINTER: next_st.next_fetch_pointer = pwdata[WIDE_W-1:0];
          OFS_USER_STACK:    next_st.user_stack_ptr = pwdata[WORD_W-1:0];
          OFS_INT_STACK:     next_st.interrupt_stack_ptr = pwdata[WORD_W-1:0];
          OFS_CPU_FLAG_WORD: next_st.stack_sel = pwdata[FLAG_STACK_SEL_BIT];
          default:           next_st.stack_sel = st.stack_sel;
        endcase
      end
      if (wr_req.en)
      begin
        case (wr_req.sel)
          SEL_DATA_WORD_0:      next_st.data_word_0 = wr_req.data[WORD_W-1:0];
          SEL_DATA_WORD_1:      next_st.data_word_1 = wr_req.data[WORD_W-1:0];
          SEL_DATA_WORD_2:      next_st.data_word_2 = wr_req.data[WORD_W-1:0];
          SEL_DATA_WORD_3:      next_st.data_word_3 = wr_req.data[WORD_W-1:0];
          SEL_WORD0_HIGH_BYTE:  next_st.data_word_0[WORD_W-1:BYTE_W] = wr_req.data[BYTE_W-1:0];
          SEL_WORD0_LOW_BYTE:   next_st.data_word_0[BYTE_W-1:0] = wr_req.data[BYTE_W-1:0];
          SEL_WORD1_HIGH_BYTE:  next_st.data_word_1[WORD_W-1:BYTE_W] = wr_req.data[BYTE_W-1:0];
          SEL_WORD1_LOW_BYTE:   next_st.data_word_1[BYTE_W-1:0] = wr_req.data[BYTE_W-1:0];
          // First long pair, upper half to word 2
          SEL_LONG_PAIR_FIRST:
          begin
            next_st.data_word_2 = wr_req.data[LONG_W-1:WORD_W];
            next_st.data_word_0 = wr_req.data[WORD_W-1:0];
          end
          // Second long pair, upper half to word 3
          SEL_LONG_PAIR_SECOND:
          begin
            next_st.data_word_3 = wr_req.data[LONG_W-1:WORD_W];
            next_st.data_word_1 = wr_req.data[WORD_W-1:0];
          end
          SEL_POINTER_LO:       next_st.pointer_lo = wr_req.data[WORD_W-1:0];
          SEL_POINTER_HI:       next_st.pointer_hi = wr_req.data[WORD_W-1:0];
          // Pointer pair, upper half to pointer high
          SEL_POINTER_PAIR:
          begin
            next_st.pointer_hi = wr_req.data[LONG_W-1:WORD_W];
            next_st.pointer_lo = wr_req.data[WORD_W-1:0];
          end
          SEL_FRAME_BASE:       next_st.frame_base = wr_req.data[WORD_W-1:0];
          // Write lands in the selected stack
          SEL_ACTIVE_STACK_PTR:
          begin
            if (st.stack_sel)
              next_st.user_stack_ptr = wr_req.data[WORD_W-1:0];
            else
              next_st.interrupt_stack_ptr = wr_req.data[WORD_W-1:0];
          end
          default:              next_st.frame_base = st.frame_base;
        endcase
      end
      if (fetch_ptr_load)
        next_st.next_fetch_pointer = fetch_ptr_value;
      if (flag_we)
        next_st.stack_sel = flag_value;
      // Interrupt entry forces the interrupt stack
      if (hw_int_ack || soft_clears)
        next_st.stack_sel = 1'b0;
      // Operand ports register the pre-write values
      next_st.rd_a = operand_read(st, rd_a_sel);
      next_st.rd_b = operand_read(st, rd_b_sel);
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '{data_word_0: RST_WORD, data_word_1: RST_WORD, data_word_2: RST_WORD,
              data_word_3: RST_WORD, pointer_lo: RST_WORD, pointer_hi: RST_WORD,
              frame_base: RST_WORD, vector_table_base: RST_WIDE,
              next_fetch_pointer: RST_WIDE, user_stack_ptr: RST_WORD,
              interrupt_stack_ptr: RST_WORD, stack_sel: 1'b0, rd_a: RST_LONG,
              rd_b: RST_LONG, prdata: RST_LONG, pslverr: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs

  // Bus answer, zero wait states while enabled
  assign pready    = ce;
  assign prdata    = st.prdata;
  assign pslverr   = st.pslverr;
  assign rd_a_data = st.rd_a;
  assign rd_b_data = st.rd_b;

  assign pointer_lo         = st.pointer_lo;
  assign pointer_hi         = st.pointer_hi;
  assign frame_base         = st.frame_base;
  assign vector_table_base  = st.vector_table_base;
  assign next_fetch_pointer = st.next_fetch_pointer;
  assign active_stack_ptr   = stack_view(st);
  assign stack_sel          = st.stack_sel;

  // ==========================================================================
  // Assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  word_write_a: assert property (
    ce && wr_req.en && wr_req.sel == SEL_DATA_WORD_3
    |=> data_word_peek(3) == $past(wr_req.data[WORD_W-1:0]))
    else $error("word write lost");

  high_byte_a: assert property (
    ce && wr_req.en && wr_req.sel == SEL_WORD0_HIGH_BYTE && !(apb_access && pwrite)
    |=> st.data_word_0[BYTE_W-1:0] == $past(st.data_word_0[BYTE_W-1:0])
        && st.data_word_0[WORD_W-1:BYTE_W] == $past(wr_req.data[BYTE_W-1:0]))
    else $error("high byte write disturbed word");

  low_byte_a: assert property (
    ce && wr_req.en && wr_req.sel == SEL_WORD1_LOW_BYTE && !(apb_access && pwrite)
    |=> $stable(st.data_word_1[WORD_W-1:BYTE_W])
        && st.data_word_1[BYTE_W-1:0] == $past(wr_req.data[BYTE_W-1:0]))
    else $error("low byte write disturbed word");

  pair_read_a: assert property (
    ce && rd_a_sel == SEL_LONG_PAIR_FIRST
    |=> rd_a_data == {$past(st.data_word_2), $past(st.data_word_0)})
    else $error("first long pair read wrong");

  pair_write_a: assert property (
    ce && wr_req.en && wr_req.sel == SEL_LONG_PAIR_SECOND
    ##1 ce && !wr_req.en && !(apb_access && pwrite)
    ##1 ce && rd_b_sel == SEL_LONG_PAIR_SECOND && !wr_req.en
    |=> rd_b_data == $past(wr_req.data, 3))
    else $error("second long pair round trip wrong");

  pointer_op_a: assert property (
    ce && rd_b_sel == SEL_POINTER_HI |=> rd_b_data == {16'h0000, $past(pointer_hi)})
    else $error("pointer operand read wrong");

  pointer_pair_a: assert property (
    ce && wr_req.en && wr_req.sel == SEL_POINTER_PAIR
    |=> {pointer_hi, pointer_lo} == $past(wr_req.data))
    else $error("pointer pair write wrong");

  stack_route_a: assert property (
    ce && wr_req.en && wr_req.sel == SEL_ACTIVE_STACK_PTR && !stack_sel && !(apb_access && pwrite)
    |=> st.interrupt_stack_ptr == $past(wr_req.data[WORD_W-1:0]) && $stable(st.user_stack_ptr))
    else $error("stack write went to wrong pointer");

  int_entry_a: assert property (
    ce && (hw_int_ack || (soft_int_exec && soft_int_num <= SOFT_INT_LAST))
    |=> !stack_sel && active_stack_ptr == st.interrupt_stack_ptr)
    else $error("interrupt entry kept user stack");

  fetch_load_a: assert property (
    ce && fetch_ptr_load |=> next_fetch_pointer == $past(fetch_ptr_value))
    else $error("fetch pointer load lost");

  pair_first_write_a: assert property (
    ce && wr_req.en && wr_req.sel == SEL_LONG_PAIR_FIRST
    |=> {st.data_word_2, st.data_word_0} == $past(wr_req.data))
    else $error("first long pair write wrong");

  frame_write_a: assert property (
    ce && wr_req.en && wr_req.sel == SEL_FRAME_BASE
    |=> frame_base == $past(wr_req.data[WORD_W-1:0]))
    else $error("frame base write lost");

  table_write_a: assert property (
    apb_access && pwrite && paddr == OFS_VECTOR_BASE
    |=> vector_table_base == $past(pwdata[WIDE_W-1:0]))
    else $error("table base write lost");

  flag_set_a: assert property (
    ce && flag_we && !hw_int_ack && !soft_clears
    |=> stack_sel == $past(flag_value))
    else $error("flag write lost");

  stall_hold_a: assert property (
    !ce |=> $stable(stack_sel) && $stable(next_fetch_pointer))
    else $error("state moved while stalled");

  byte_read_a: assert property (
    ce && rd_a_sel == SEL_WORD0_HIGH_BYTE
    |=> rd_a_data == {24'h000000, $past(st.data_word_0[WORD_W-1:BYTE_W])})
    else $error("high byte operand read wrong");

  pointer_read_a: assert property (
    ce && rd_b_sel == SEL_POINTER_LO
    |=> rd_b_data == {16'h0000, $past(pointer_lo)})
    else $error("pointer low operand read wrong");

  soft_keep_a: assert property (
    ce && soft_int_exec && soft_int_num > SOFT_INT_LAST && !hw_int_ack && !flag_we
    && !(apb_access && pwrite)
    |=> $stable(stack_sel))
    else $error("high software interrupt changed flag");

  // Helper view of one data word for the checks
  function automatic logic [WORD_W-1:0] data_word_peek(int idx);
    case (idx)
      0:       return st.data_word_0;
      1:       return st.data_word_1;
      2:       return st.data_word_2;
      default: return st.data_word_3;
    endcase
  endfunction

endmodule // cpu_core_register_set

// [shared/cpu_regs_pkg.sv]
// Package for the core register set: widths, selector codes, bus map, carriers.
// Assumes a single core clock domain and an APB register port with 32-bit data.
package cpu_regs_pkg;

  // ==========================================================================
  // Widths
  localparam int WORD_W  = 16;
  localparam int BYTE_W  = 8;
  localparam int LONG_W  = 32;
  localparam int WIDE_W  = 20;
  localparam int PADDR_W = 12;
  localparam int INTNUM_W = 6;

  // Highest software interrupt number that forces the interrupt stack
  localparam logic [INTNUM_W-1:0] SOFT_INT_LAST = 6'h1f;

  // ==========================================================================
  // APB byte offsets
  localparam logic [PADDR_W-1:0] OFS_DATA_WORD_0   = 12'h000;
  localparam logic [PADDR_W-1:0] OFS_DATA_WORD_1   = 12'h004;
  localparam logic [PADDR_W-1:0] OFS_DATA_WORD_2   = 12'h008;
  localparam logic [PADDR_W-1:0] OFS_DATA_WORD_3   = 12'h00c;
  localparam logic [PADDR_W-1:0] OFS_POINTER_LO    = 12'h010;
  localparam logic [PADDR_W-1:0] OFS_POINTER_HI    = 12'h014;
  localparam logic [PADDR_W-1:0] OFS_FRAME_BASE    = 12'h018;
  localparam logic [PADDR_W-1:0] OFS_VECTOR_BASE   = 12'h01c;
  localparam logic [PADDR_W-1:0] OFS_FETCH_POINTER = 12'h020;
  localparam logic [PADDR_W-1:0] OFS_USER_STACK    = 12'h024;
  localparam logic [PADDR_W-1:0] OFS_INT_STACK     = 12'h028;
  localparam logic [PADDR_W-1:0] OFS_CPU_FLAG_WORD = 12'h02c;

  // Reset values
  localparam logic [WORD_W-1:0] RST_WORD = 16'h0000;
  localparam logic [WIDE_W-1:0] RST_WIDE = 20'h00000;
  localparam logic [LONG_W-1:0] RST_LONG = 32'h00000000;

  // Bit position of the stack-select flag in the flag word
  localparam int FLAG_STACK_SEL_BIT = 0;

  // ==========================================================================
  // Operand selectors used by the execution datapath
  typedef enum logic [3:0] {
    SEL_DATA_WORD_0,
    SEL_DATA_WORD_1,
    SEL_DATA_WORD_2,
    SEL_DATA_WORD_3,
    SEL_WORD0_HIGH_BYTE,
    SEL_WORD0_LOW_BYTE,
    SEL_WORD1_HIGH_BYTE,
    SEL_WORD1_LOW_BYTE,
    SEL_LONG_PAIR_FIRST,
    SEL_LONG_PAIR_SECOND,
    SEL_POINTER_LO,
    SEL_POINTER_HI,
    SEL_POINTER_PAIR,
    SEL_FRAME_BASE,
    SEL_ACTIVE_STACK_PTR
  } reg_sel_t;

  // Datapath write request
  typedef struct packed {
    logic              en;
    reg_sel_t          sel;
    logic [LONG_W-1:0] data;
  } wr_req_t;

  // Whole register-set state
  typedef struct packed {
    logic [WORD_W-1:0] data_word_0;
    logic [WORD_W-1:0] data_word_1;
    logic [WORD_W-1:0] data_word_2;
    logic [WORD_W-1:0] data_word_3;
    logic [WORD_W-1:0] pointer_lo;
    logic [WORD_W-1:0] pointer_hi;
    logic [WORD_W-1:0] frame_base;
    logic [WIDE_W-1:0] vector_table_base;
    logic [WIDE_W-1:0] next_fetch_pointer;
    logic [WORD_W-1:0] user_stack_ptr;
    logic [WORD_W-1:0] interrupt_stack_ptr;
    logic              stack_sel;
    logic [LONG_W-1:0] rd_a;
    logic [LONG_W-1:0] rd_b;
    logic [LONG_W-1:0] prdata;
    logic              pslverr;
  } regs_state_t;

endpackage

// [verification/dp_model.sv]
// Behavioural model of the execution datapath facing the register set.
// Assumes requests are sampled on the rising edge of pclk while ce is high.
`timescale 1ns/1ps

module dp_model
  import cpu_regs_pkg::*;
(
  input  wire logic                pclk,            // Core clock
  input  wire logic [LONG_W-1:0]   rd_a_data,       // Operand A value
  input  wire logic [LONG_W-1:0]   rd_b_data,       // Operand B value
  output reg_sel_t                 rd_a_sel,        // Operand A selector
  output reg_sel_t                 rd_b_sel,        // Operand B selector
  output wr_req_t                  wr_req,          // Operand write request
  output logic                     fetch_ptr_load,  // Fetch pointer load
  output logic [WIDE_W-1:0]        fetch_ptr_value, // Fetch pointer value
  output logic                     flag_we,         // Flag write
  output logic                     flag_value,      // Flag value
  output logic                     hw_int_ack,      // Hardware interrupt taken
  output logic                     soft_int_exec,   // Software interrupt
  output logic [INTNUM_W-1:0]      soft_int_num     // Software interrupt number
);
  // ==========================================================================
  // Idle values at time zero
  initial
  begin
    rd_a_sel = SEL_DATA_WORD_0;
    rd_b_sel = SEL_DATA_WORD_1;
    wr_req = '{1'b0, SEL_DATA_WORD_0, 32'h00000000};
    {fetch_ptr_load, flag_we, flag_value, hw_int_ack, soft_int_exec} = 5'h00;
    fetch_ptr_value = 20'h00000;
    soft_int_num = 6'h00;
  end

  // One operand write; data is scrambled once released
  task automatic wr(input reg_sel_t s, input logic [LONG_W-1:0] d);
    @(posedge pclk);
    wr_req <= '{1'b1, s, d};
    @(posedge pclk);
    wr_req.en <= 1'b0;
    wr_req.data <= ~d;
  endtask

  // Two operand reads; values arrive one cycle after the selectors
  task automatic rd2(input reg_sel_t sa, input reg_sel_t sb,
                     output logic [LONG_W-1:0] qa, output logic [LONG_W-1:0] qb);
    @(posedge pclk);
    rd_a_sel <= sa;
    rd_b_sel <= sb;
    @(posedge pclk);
    #1;
    qa = rd_a_data;
    qb = rd_b_data;
  endtask

  // Control pulse: 0 hw ack, 1 soft int, 2 flag write, 3 fetch load
  task automatic sig(input int k, input logic [WIDE_W-1:0] v);
    @(posedge pclk);
    case (k)
      0: hw_int_ack <= 1'b1;
      1: {soft_int_exec, soft_int_num} <= {1'b1, v[INTNUM_W-1:0]};
      2: {flag_we, flag_value} <= {1'b1, v[0]};
      default: {fetch_ptr_load, fetch_ptr_value} <= {1'b1, v};
    endcase
    @(posedge pclk);
    {fetch_ptr_load, flag_we, hw_int_ack, soft_int_exec} <= 4'h0;
    soft_int_num <= ~soft_int_num;
    fetch_ptr_value <= ~fetch_ptr_value;
    flag_value <= ~flag_value;
  endtask
endmodule // dp_model

// [verification/tb.sv]
// Self-checking bench for the core register set over APB and the datapath.
// Assumes the datapath model file and the package are compiled first.
`timescale 1ns/1ps

module tb
  import cpu_regs_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, stack_sel;
  logic [PADDR_W-1:0] paddr = 12'h000;
  logic [LONG_W-1:0]  pwdata = 32'h00000000, prdata, rd_a_data, rd_b_data, q, q2;
  reg_sel_t rd_a_sel, rd_b_sel;
  wr_req_t wr_req;
  logic fetch_ptr_load, flag_we, flag_value, hw_int_ack, soft_int_exec, e;
  logic [WIDE_W-1:0] fetch_ptr_value, vector_table_base, next_fetch_pointer;
  logic [INTNUM_W-1:0] soft_int_num;
  logic [WORD_W-1:0] pointer_lo, pointer_hi, frame_base, active_stack_ptr;
  int fails = 0, tests_run = 0;

  // ==========================================================================
  // Clock and instances
  always #2 pclk = ~pclk;

  cpu_core_register_set DUT (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .rd_a_sel, .rd_b_sel, .rd_a_data, .rd_b_data,
    .wr_req, .fetch_ptr_load, .fetch_ptr_value, .flag_we, .flag_value, .hw_int_ack,
    .soft_int_exec, .soft_int_num, .pointer_lo, .pointer_hi, .frame_base,
    .vector_table_base, .next_fetch_pointer, .active_stack_ptr, .stack_sel);

  dp_model dp (.pclk, .rd_a_data, .rd_b_data, .rd_a_sel, .rd_b_sel, .wr_req,
    .fetch_ptr_load, .fetch_ptr_value, .flag_we, .flag_value, .hw_int_ack,
    .soft_int_exec, .soft_int_num);

  // ==========================================================================
  // Tasks
  task automatic chk(input string nm, input logic [LONG_W-1:0] ex, input logic [LONG_W-1:0] got);
    tests_run++;
    if (got !== ex)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // One APB transfer; waits for pready, the watchdog ends a hang
  task automatic apb(input logic w, input logic [PADDR_W-1:0] a, input logic [LONG_W-1:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================================
  // Watchdog
  initial
  begin
    repeat (5000) @(posedge pclk);
    fails++;
    report_and_stop();
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, then all-ones written and read back masked to width
    for (int i = 0; i < 12; i++)
    begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk("reset value", 32'h0, q);
      apb(1'b1, 12'(i * 4), 32'hffffffff);
      apb(1'b0, 12'(i * 4), 32'h0);
      q2 = (i == 7 || i == 8) ? 32'h000fffff : (i == 11) ? 32'h1 : 32'hffff;
      chk("reg width", q2, q);
    end
    chk("table base view", 32'h000fffff, {12'h0, vector_table_base});
    apb(1'b0, 12'h030, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    apb(1'b0, 12'h002, 32'h0);
    chk("unaligned err", 32'h1, {31'h0, e});
    // Byte halves
    dp.wr(SEL_DATA_WORD_0, 32'h1234);
    dp.wr(SEL_WORD0_HIGH_BYTE, 32'h00ab);
    apb(1'b0, OFS_DATA_WORD_0, 32'h0);
    chk("word0 high byte", 32'hab34, q);
    dp.wr(SEL_WORD1_LOW_BYTE, 32'h5a);
    dp.wr(SEL_WORD1_HIGH_BYTE, 32'h12);
    apb(1'b0, OFS_DATA_WORD_1, 32'h0);
    chk("word1 bytes", 32'h125a, q);
    // Long pairs, pointer pair, operand reads and frame base
    dp.wr(SEL_LONG_PAIR_FIRST, 32'h89abcdef);
    apb(1'b0, OFS_DATA_WORD_2, 32'h0);
    chk("pair first upper", 32'h89ab, q);
    dp.wr(SEL_LONG_PAIR_SECOND, 32'h01234567);
    dp.rd2(SEL_DATA_WORD_3, SEL_LONG_PAIR_SECOND, q2, q);
    chk("pair second", 32'h01234567, q);
    chk("word3", 32'h0123, q2);
    dp.wr(SEL_POINTER_PAIR, 32'hbeef0042);
    #1 chk("pointer pair", 32'hbeef0042, {pointer_hi, pointer_lo});
    dp.rd2(SEL_LONG_PAIR_FIRST, SEL_POINTER_LO, q2, q);
    chk("pointer operand", 32'h0042, q);
    chk("pair first read", 32'h89abcdef, q2);
    dp.wr(SEL_DATA_WORD_3, 32'h0000c3c3);
    dp.rd2(SEL_DATA_WORD_3, SEL_POINTER_HI, q, q2);
    chk("word3 write", 32'hc3c3, q);
    chk("pointer hi operand", 32'hbeef, q2);
    dp.rd2(SEL_WORD0_HIGH_BYTE, SEL_WORD1_HIGH_BYTE, q, q2);
    chk("byte reads", 32'h00cd0045, {q[15:0], q2[15:0]});
    dp.wr(SEL_FRAME_BASE, 32'h7777);
    #1 chk("frame base", 32'h7777, {16'h0, frame_base});
    // Stack select, then fetch pointer load
    apb(1'b1, OFS_USER_STACK, 32'h1111);
    apb(1'b1, OFS_INT_STACK, 32'h2222);
    #1 chk("user stack active", 32'h1111, {16'h0, active_stack_ptr});
    dp.sig(0, 20'h0);
    #1 chk("hw ack clears", 32'h2222, {15'h0, stack_sel, active_stack_ptr});
    dp.wr(SEL_ACTIVE_STACK_PTR, 32'h3333);
    apb(1'b0, OFS_INT_STACK, 32'h0);
    chk("active write", 32'h3333, q);
    dp.sig(2, 20'h1);
    dp.sig(1, 20'h1f);
    #1 chk("soft int 31", 32'h0, {31'h0, stack_sel});
    dp.sig(2, 20'h1);
    dp.sig(1, 20'h20);
    #1 chk("soft int 32", 32'h1, {31'h0, stack_sel});
    dp.sig(3, 20'habcde);
    #1 chk("fetch pointer", 32'habcde, {12'h0, next_fetch_pointer});
    // Clock enable low freezes state and stalls the bus
    @(posedge pclk);
    ce <= 1'b0;
    dp.sig(0, 20'h0);
    #1 chk("frozen", 32'h1, {30'h0, pready, stack_sel});
    @(posedge pclk);
    ce <= 1'b1;
    report_and_stop();
  end
endmodule // tb
